/* hw/csf_pkg.sv */
package csf_pkg;

	// =====================================================================
	// register map (byte addresses, one aligned 32-bit word each)
	// =====================================================================
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_INT_STATUS = 8'h08;
	localparam logic [7:0] OFF_INT_MASK = 8'h0C;
	localparam logic [7:0] OFF_OUT_IMAGE = 8'h10;
	localparam logic [7:0] OFF_OUT_LATCH_SET = 8'h14;
	localparam logic [7:0] OFF_OUT_STATE = 8'h18;

	// =====================================================================
	// field positions
	// =====================================================================
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_TICK_HOLD_BIT = 1;
	localparam int CTRL_ALL_OFF_BIT = 2;

	localparam int STAT_CARRY_BIT = 0;
	localparam int STAT_FAULT_BIT = 1;
	localparam int STAT_NODE1_BIT = 2;
	localparam int STAT_NODE2_BIT = 3;
	localparam int STAT_RUNNING_BIT = 4;
	localparam int STAT_TICK_BIT = 5;

	localparam int INT_W = 4;
	localparam int INT_FAULT_BIT = 0;
	localparam int INT_NODE1_BIT = 1;
	localparam int INT_NODE2_BIT = 2;
	localparam int INT_STOP_BIT = 3;

	localparam int N_OUT = 8;

	// =====================================================================
	// reset values
	// =====================================================================
	localparam logic [INT_W-1:0] INT_MASK_RST = 4'h0;
	localparam logic [N_OUT-1:0] OUT_IMAGE_RST = 8'h00;
	localparam logic [31:0] RDATA_RST = 32'h00000000;

	// =====================================================================
	// timing
	// =====================================================================
	localparam int CLK_MHZ = 200;
	localparam int TICK_HALF_MS = 500;
	localparam int TICK_HALF_CYCLES = TICK_HALF_MS * 1000 * CLK_MHZ;
	localparam int TICK_CNT_W = 32;

	// =====================================================================
	// run state
	// =====================================================================
	typedef enum logic [2:0] {
		ST_RESTORE = 3'b001,
		ST_STOPPED = 3'b010,
		ST_RUNNING = 3'b100
	} csf_run_state_t;

endpackage

/* hw/csf_tick_gen.sv */
`timescale 1ns/1ps
module csf_tick_gen import csf_pkg::*; #(
	parameter int HALF_CYCLES = TICK_HALF_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic hold_in,
	output logic tick_out
);

	logic [TICK_CNT_W-1:0] cnt;
	logic [TICK_CNT_W-1:0] next_cnt;
	logic next_tick;

	// =====================================================================
	// half-period counter; hold restarts the period from zero
	// =====================================================================
	always_comb begin
		next_cnt = cnt;
		next_tick = tick_out;
		if (hold_in) begin
			next_cnt = '0;
			next_tick = 1'b0;
		end else if (cnt == TICK_CNT_W'(HALF_CYCLES - 1)) begin
			next_cnt = '0;
			next_tick = ~tick_out;
		end else begin
			next_cnt = cnt + TICK_CNT_W'(1);
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt <= '0;
			tick_out <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick_out <= next_tick;
		end
	end

endmodule // csf_tick_gen

/* hw/csf_out_gate.sv */
`timescale 1ns/1ps
module csf_out_gate import csf_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic running_in,
	input wire logic all_off_in,
	input wire logic [N_OUT-1:0] image_in,
	input wire logic [N_OUT-1:0] latch_set_in,
	output logic [N_OUT-1:0] out_state_out
);

	// =====================================================================
	// per-output self-latch and final gating
	// =====================================================================
	genvar i;
	generate
		for (i = 0; i < N_OUT; i++) begin : g_out
			logic latch;
			logic next_latch;
			logic next_out;
			always_comb begin
				next_latch = latch;
				if (!running_in || all_off_in) begin
					// a dropped latch needs a fresh set once the force is lifted
					next_latch = 1'b0;
				end else if (latch_set_in[i]) begin
					next_latch = 1'b1;
				end
				next_out = running_in && !all_off_in && (image_in[i] || next_latch);
			end
			always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					latch <= 1'b0;
					out_state_out[i] <= 1'b0;
				end else begin
					latch <= next_latch;
					out_state_out[i] <= next_out;
				end
			end
		end
	endgenerate

endmodule // csf_out_gate

/* hw/csf_flag_bank.sv */
`timescale 1ns/1ps
// Operation
// - Setting the run control flag starts program execution and clearing it stops execution.
// - An active stop input or reset input keeps execution stopped whatever the run flag says.
// - The run control flag is restored from retained storage when power returns.
// - With corrupted retained data the run flag takes the configured backup-error selection.
// - While the tick hold flag is set the one-second tick flag is forced to zero.
// - Setting the all-outputs-off flag drives every output off.
// - Self-latched outputs drop when outputs are forced off and stay off after the force ends.
// - The carry/borrow flag is set by an addition carry or a subtraction borrow.
// - Shift and rotate operations put the bit moved out into the carry/borrow flag.
// - The program fault flag is set when an execution error occurs in the program.
// - Remote nodes 1 and 2 each have their own link fault flag set on a failed link.
module csf_flag_bank import csf_pkg::*; #(
	parameter int TICK_HALF = TICK_HALF_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic irq_out,
	input wire logic stop_in,
	input wire logic reset_in,
	input wire logic retained_run_in,
	input wire logic backup_valid_in,
	input wire logic backup_err_run_sel_in,
	output logic retained_run_out,
	input wire logic add_valid_in,
	input wire logic carry_indication_in,
	input wire logic sub_valid_in,
	input wire logic borrow_indication_in,
	input wire logic shift_valid_in,
	input wire logic shift_out_bit_in,
	input wire logic exec_error_in,
	input wire logic node1_link_fail_in,
	input wire logic node2_link_fail_in,
	output logic run_active_out,
	output logic one_second_tick_flag_out,
	output logic [N_OUT-1:0] outputs_out
);

	// =====================================================================
	// declarations
	// =====================================================================
	csf_run_state_t state;
	csf_run_state_t next_state;
	logic run_control_flag;
	logic next_run_control_flag;
	logic next_run_active;
	logic tick_hold_flag;
	logic next_tick_hold_flag;
	logic all_outputs_off_flag;
	logic next_all_outputs_off_flag;
	logic carry_borrow_flag;
	logic next_carry_borrow_flag;
	logic program_fault_flag;
	logic next_program_fault_flag;
	logic remote_node1_link_fault;
	logic next_remote_node1_link_fault;
	logic remote_node2_link_fault;
	logic next_remote_node2_link_fault;
	logic [INT_W-1:0] int_status;
	logic [INT_W-1:0] next_int_status;
	logic [INT_W-1:0] int_mask;
	logic [INT_W-1:0] next_int_mask;
	logic [INT_W-1:0] int_event;
	logic [INT_W-1:0] int_clear;
	logic next_irq;
	logic [N_OUT-1:0] out_image;
	logic [N_OUT-1:0] next_out_image;
	logic [N_OUT-1:0] latch_set;
	logic [N_OUT-1:0] next_latch_set;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic access;
	logic done;
	logic mapped;
	logic wr_ctrl;
	logic running;
	logic hold_run;
	logic tick_flag;
	logic [N_OUT-1:0] out_state;

	// =====================================================================
	// apb decode
	// =====================================================================
	assign access = psel_in && penable_in;
	assign done = access && pready_out;
	assign running = (state == ST_RUNNING);
	assign hold_run = !stop_in && !reset_in;
	assign wr_ctrl = done && pwrite_in && (paddr_in == OFF_CTRL);

	always_comb begin
		unique case (paddr_in)
			OFF_CTRL, OFF_STATUS, OFF_INT_STATUS, OFF_INT_MASK,
			OFF_OUT_IMAGE, OFF_OUT_LATCH_SET, OFF_OUT_STATE: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// =====================================================================
	// apb answer: one wait state, read data taken in that wait state
	// =====================================================================
	always_comb begin
		next_pready = access && !pready_out;
		next_pslverr = 1'b0;
		next_prdata = RDATA_RST;
		if (access && !pready_out) begin
			next_pslverr = !mapped;
			if (!pwrite_in) begin
				// reserved bits and unmapped words read as zero
				unique case (paddr_in)
					OFF_CTRL: begin
						next_prdata[CTRL_RUN_BIT] = run_control_flag;
						next_prdata[CTRL_TICK_HOLD_BIT] = tick_hold_flag;
						next_prdata[CTRL_ALL_OFF_BIT] = all_outputs_off_flag;
					end
					OFF_STATUS: begin
						next_prdata[STAT_CARRY_BIT] = carry_borrow_flag;
						next_prdata[STAT_FAULT_BIT] = program_fault_flag;
						next_prdata[STAT_NODE1_BIT] = remote_node1_link_fault;
						next_prdata[STAT_NODE2_BIT] = remote_node2_link_fault;
						next_prdata[STAT_RUNNING_BIT] = running;
						next_prdata[STAT_TICK_BIT] = tick_flag;
					end
					OFF_INT_STATUS: next_prdata[INT_W-1:0] = int_status;
					OFF_INT_MASK: next_prdata[INT_W-1:0] = int_mask;
					OFF_OUT_IMAGE: next_prdata[N_OUT-1:0] = out_image;
					OFF_OUT_STATE: next_prdata[N_OUT-1:0] = out_state;
					default: next_prdata = RDATA_RST;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= RDATA_RST;
		end else begin
			pready_out <= next_pready;
			pslverr_out <= next_pslverr;
			prdata_out <= next_prdata;
		end
	end

	// =====================================================================
	// run control
	// =====================================================================
	always_comb begin
		next_state = state;
		next_run_control_flag = run_control_flag;
		unique case (state)
			ST_RESTORE: begin
				// reset can only load a constant, so the retained level is taken here
				if (backup_valid_in) begin
					next_run_control_flag = retained_run_in;
				end else begin
					next_run_control_flag = backup_err_run_sel_in;
				end
				next_state = ST_STOPPED;
			end
			ST_STOPPED: begin
				if (run_control_flag && hold_run) begin
					next_state = ST_RUNNING;
				end
			end
			ST_RUNNING: begin
				if (!run_control_flag || !hold_run) begin
					next_state = ST_STOPPED;
				end
			end
			default: next_state = ST_STOPPED;
		endcase
		if (state != ST_RESTORE && wr_ctrl) begin
			next_run_control_flag = pwdata_in[CTRL_RUN_BIT];
		end
		next_run_active = (next_state == ST_RUNNING);
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= ST_RESTORE;
			run_control_flag <= 1'b0;
			run_active_out <= 1'b0;
		end else begin
			state <= next_state;
			run_control_flag <= next_run_control_flag;
			run_active_out <= next_run_active;
		end
	end

	// =====================================================================
	// special flags
	// =====================================================================
	always_comb begin
		next_tick_hold_flag = tick_hold_flag;
		next_all_outputs_off_flag = all_outputs_off_flag;
		next_carry_borrow_flag = carry_borrow_flag;
		next_program_fault_flag = program_fault_flag;
		if (wr_ctrl) begin
			next_tick_hold_flag = pwdata_in[CTRL_TICK_HOLD_BIT];
			next_all_outputs_off_flag = pwdata_in[CTRL_ALL_OFF_BIT];
		end
		if (add_valid_in) begin
			next_carry_borrow_flag = carry_indication_in;
		end else if (sub_valid_in) begin
			next_carry_borrow_flag = borrow_indication_in;
		end else if (shift_valid_in) begin
			next_carry_borrow_flag = shift_out_bit_in;
		end
		if (exec_error_in) begin
			next_program_fault_flag = 1'b1;
		end
		if (!running) begin
			next_tick_hold_flag = 1'b0;
			next_all_outputs_off_flag = 1'b0;
			next_carry_borrow_flag = 1'b0;
			next_program_fault_flag = 1'b0;
		end
		// link faults follow the links whether or not the program runs
		next_remote_node1_link_fault = node1_link_fail_in;
		next_remote_node2_link_fault = node2_link_fail_in;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tick_hold_flag <= 1'b0;
			all_outputs_off_flag <= 1'b0;
			carry_borrow_flag <= 1'b0;
			program_fault_flag <= 1'b0;
			remote_node1_link_fault <= 1'b0;
			remote_node2_link_fault <= 1'b0;
		end else begin
			tick_hold_flag <= next_tick_hold_flag;
			all_outputs_off_flag <= next_all_outputs_off_flag;
			carry_borrow_flag <= next_carry_borrow_flag;
			program_fault_flag <= next_program_fault_flag;
			remote_node1_link_fault <= next_remote_node1_link_fault;
			remote_node2_link_fault <= next_remote_node2_link_fault;
		end
	end

	// =====================================================================
	// interrupts: sticky, cleared by reading, set wins over clear
	// =====================================================================
	always_comb begin
		int_event = '0;
		int_event[INT_FAULT_BIT] = next_program_fault_flag && !program_fault_flag;
		int_event[INT_NODE1_BIT] = next_remote_node1_link_fault && !remote_node1_link_fault;
		int_event[INT_NODE2_BIT] = next_remote_node2_link_fault && !remote_node2_link_fault;
		int_event[INT_STOP_BIT] = running && (next_state == ST_STOPPED);
		// only the bits the reader saw are cleared, so nothing slips past
		int_clear = '0;
		if (done && !pwrite_in && paddr_in == OFF_INT_STATUS) begin
			int_clear = prdata_out[INT_W-1:0];
		end
		next_int_status = (int_status & ~int_clear) | int_event;
		next_int_mask = int_mask;
		if (done && pwrite_in && paddr_in == OFF_INT_MASK) begin
			next_int_mask = pwdata_in[INT_W-1:0];
		end
		next_irq = |(next_int_status & next_int_mask);
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			int_status <= '0;
			int_mask <= INT_MASK_RST;
			irq_out <= 1'b0;
		end else begin
			int_status <= next_int_status;
			int_mask <= next_int_mask;
			irq_out <= next_irq;
		end
	end

	// =====================================================================
	// output image and latch set strobes
	// =====================================================================
	always_comb begin
		next_out_image = out_image;
		next_latch_set = '0;
		if (done && pwrite_in && paddr_in == OFF_OUT_IMAGE) begin
			next_out_image = pwdata_in[N_OUT-1:0];
		end
		if (done && pwrite_in && paddr_in == OFF_OUT_LATCH_SET) begin
			next_latch_set = pwdata_in[N_OUT-1:0];
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_image <= OUT_IMAGE_RST;
			latch_set <= '0;
		end else begin
			out_image <= next_out_image;
			latch_set <= next_latch_set;
		end
	end

	// =====================================================================
	// submodules
	// =====================================================================
	csf_tick_gen #(
		.HALF_CYCLES(TICK_HALF)
	) u_tick (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.hold_in(tick_hold_flag),
		.tick_out(tick_flag)
	);

	csf_out_gate u_out (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.running_in(running),
		.all_off_in(all_outputs_off_flag),
		.image_in(out_image),
		.latch_set_in(latch_set),
		.out_state_out(out_state)
	);

	assign retained_run_out = run_control_flag;
	assign one_second_tick_flag_out = tick_flag;
	assign outputs_out = out_state;

endmodule // csf_flag_bank

/* sim/csf_prog_model.sv */
`timescale 1ns/1ps
module csf_prog_model (
	input wire logic ref_clk_in,
	output logic add_valid_out,
	output logic carry_indication_out,
	output logic sub_valid_out,
	output logic borrow_indication_out,
	output logic shift_valid_out,
	output logic shift_out_bit_out,
	output logic exec_error_out,
	output logic node1_link_fail_out,
	output logic node2_link_fail_out
);
	// ==========
	// program side and remote nodes
	initial begin
		{add_valid_out, sub_valid_out, shift_valid_out, exec_error_out} = 4'h0;
		{carry_indication_out, borrow_indication_out, shift_out_bit_out} = 3'h0;
		{node1_link_fail_out, node2_link_fail_out} = 2'h0;
	end

	task automatic op(input int kind, input logic b);
		@(posedge ref_clk_in);
		add_valid_out <= (kind == 0);
		sub_valid_out <= (kind == 1);
		shift_valid_out <= (kind == 2);
		{carry_indication_out, borrow_indication_out, shift_out_bit_out} <= {3{b}};
		@(posedge ref_clk_in);
		{add_valid_out, sub_valid_out, shift_valid_out} <= 3'h0;
		// data is not held past the pulse, so it turns over rather than lingering
		{carry_indication_out, borrow_indication_out, shift_out_bit_out} <= {3{~b}};
	endtask

	task automatic fault();
		@(posedge ref_clk_in);
		exec_error_out <= 1'b1;
		@(posedge ref_clk_in);
		exec_error_out <= 1'b0;
	endtask

	task automatic node(input int n, input logic v);
		@(posedge ref_clk_in);
		if (n == 1) begin
			node1_link_fail_out <= v;
		end else begin
			node2_link_fail_out <= v;
		end
	endtask
endmodule // csf_prog_model

/* sim/csf_flag_bank_assertions.sv */
`timescale 1ns/1ps
module csf_flag_bank_checker import csf_pkg::*; #(
	parameter int TICK_HALF = TICK_HALF_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input logic [31:0] prdata_out,
	input logic pready_out,
	input logic pslverr_out,
	input logic irq_out,
	input wire logic stop_in,
	input wire logic reset_in,
	input wire logic retained_run_in,
	input wire logic backup_valid_in,
	input wire logic backup_err_run_sel_in,
	input logic retained_run_out,
	input wire logic node1_link_fail_in,
	input wire logic node2_link_fail_in,
	input logic run_active_out,
	input logic [N_OUT-1:0] outputs_out
);
	// ==========
	// helper state
	logic [1:0] cnt;
	logic [1:0] next_cnt;
	logic exp_run;
	logic next_exp_run;
	logic mask_seen;
	logic next_mask_seen;
	logic mapped;
	logic rd_stat;
	assign mapped = paddr_in[1:0] == 2'h0 && paddr_in <= OFF_OUT_STATE;
	assign rd_stat = pready_out && !pwrite_in && paddr_in == OFF_STATUS;
	always_comb begin
		next_cnt = (cnt == 2'h3) ? cnt : cnt + 2'h1;
		next_exp_run = backup_valid_in ? retained_run_in : backup_err_run_sel_in;
		next_mask_seen = mask_seen | (pready_out && pwrite_in && paddr_in == OFF_INT_MASK);
	end
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt <= 2'h0;
			exp_run <= 1'b0;
			mask_seen <= 1'b0;
		end else begin
			cnt <= next_cnt;
			exp_run <= next_exp_run;
			mask_seen <= next_mask_seen;
		end
	end

	// ==========
	// properties
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	a_pready_pulse: assert property (pready_out |=> !pready_out)
		else $error("pready longer than one cycle");
	a_pready_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
		else $error("pready not after one wait state");
	a_err_unmapped: assert property (pready_out && !mapped |-> pslverr_out && prdata_out == 32'h0)
		else $error("unmapped access not refused");
	a_ok_mapped: assert property (pready_out && mapped |-> !pslverr_out)
		else $error("mapped access refused");
	a_stop_wins: assert property ((stop_in || reset_in) [*3] |-> !run_active_out)
		else $error("running under stop");
	a_out_stopped: assert property (!run_active_out [*3] |-> outputs_out == '0)
		else $error("outputs on while stopped");
	a_irq_unmasked: assert property (!mask_seen |-> !irq_out)
		else $error("irq with mask clear");
	a_node1_flag: assert property (rd_stat && $past(node1_link_fail_in, 2) ==
		$past(node1_link_fail_in, 3) |-> prdata_out[STAT_NODE1_BIT] == $past(node1_link_fail_in, 2))
		else $error("node1 flag wrong");
	a_node2_flag: assert property (rd_stat && $past(node2_link_fail_in, 2) ==
		$past(node2_link_fail_in, 3) |-> prdata_out[STAT_NODE2_BIT] == $past(node2_link_fail_in, 2))
		else $error("node2 flag wrong");
	a_run_restore: assert property (cnt == 2'h1 |-> retained_run_out == exp_run)
		else $error("run flag not restored");
	a_run_start: assert property (cnt == 2'h1 && retained_run_out && !stop_in && !reset_in
		|-> ##2 run_active_out)
		else $error("no start with run flag");
endmodule // csf_flag_bank_checker

bind csf_flag_bank csf_flag_bank_checker #(.TICK_HALF(TICK_HALF)) i_csf_flag_bank_checker (
	.ref_clk_in(ref_clk_in),
	.rst_n_in(rst_n_in),
	.psel_in(psel_in),
	.penable_in(penable_in),
	.pwrite_in(pwrite_in),
	.paddr_in(paddr_in),
	.prdata_out(prdata_out),
	.pready_out(pready_out),
	.pslverr_out(pslverr_out),
	.irq_out(irq_out),
	.stop_in(stop_in),
	.reset_in(reset_in),
	.retained_run_in(retained_run_in),
	.backup_valid_in(backup_valid_in),
	.backup_err_run_sel_in(backup_err_run_sel_in),
	.retained_run_out(retained_run_out),
	.node1_link_fail_in(node1_link_fail_in),
	.node2_link_fail_in(node2_link_fail_in),
	.run_active_out(run_active_out),
	.outputs_out(outputs_out)
);

/* sim/csf_flag_bank_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, a) begin \
	comparisons++; \
	if ((a) !== (e)) begin \
		err_count++; \
		$display("[ERR] %s exp %0h got %0h", nm, (e), (a)); \
	end \
end
module csf_flag_bank_tb import csf_pkg::*;;
	logic clk, rst_n, psel, penable, pwrite, stop, halt, rr, bv, bsel;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, irq, rro, run_active, tick;
	logic [N_OUT-1:0] outs;
	logic add_v, carry, sub_v, borrow, sh_v, sh_b, xerr, n1, n2;
	int err_count = 0;
	int comparisons = 0;
	int cyc = 0;

	always #2.5 clk = ~clk;

	// short tick period keeps the run small
	csf_flag_bank #(.TICK_HALF(8)) i_csf_flag_bank (
		.ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .irq_out(irq), .stop_in(stop),
		.reset_in(halt), .retained_run_in(rr), .backup_valid_in(bv),
		.backup_err_run_sel_in(bsel), .retained_run_out(rro), .add_valid_in(add_v),
		.carry_indication_in(carry), .sub_valid_in(sub_v), .borrow_indication_in(borrow),
		.shift_valid_in(sh_v), .shift_out_bit_in(sh_b), .exec_error_in(xerr),
		.node1_link_fail_in(n1), .node2_link_fail_in(n2), .run_active_out(run_active),
		.one_second_tick_flag_out(tick), .outputs_out(outs));

	csf_prog_model i_csf_prog_model (
		.ref_clk_in(clk), .add_valid_out(add_v), .carry_indication_out(carry),
		.sub_valid_out(sub_v), .borrow_indication_out(borrow), .shift_valid_out(sh_v),
		.shift_out_bit_out(sh_b), .exec_error_out(xerr), .node1_link_fail_out(n1),
		.node2_link_fail_out(n2));

	// ==========
	// bus tasks
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
			input string nm);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		`CHK(nm, x, r & m)
	endtask

	task automatic final_report();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ==========
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			final_report();
		end
	end

	// ==========
	// tests
	initial begin
		logic [31:0] r;
		logic e;
		bit seen;
		int kind [5] = '{0, 1, 1, 2, 2};
		bit bits [5] = '{1, 0, 1, 0, 1};
		{clk, rst_n, psel, penable, pwrite, stop, halt, rr, bsel} = '0;
		{bv, paddr, pwdata} = {1'b1, 8'h00, 32'h0};
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK("run kept off", 1'b0, rro)
		`CHK("not running", 1'b0, run_active)
		`CHK("tick rst", 1'b0, tick)
		chk(OFF_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl rst");
		// the tick runs free from reset, so its status bit is left to the tick checks
		chk(OFF_STATUS, 32'h0000001F, 32'h0, "status rst");
		chk(OFF_INT_MASK, 32'hFFFFFFFF, {28'h0, INT_MASK_RST}, "mask rst");
		chk(OFF_OUT_IMAGE, 32'hFFFFFFFF, {24'h0, OUT_IMAGE_RST}, "image rst");
		// a retained run flag of one must survive a power cycle
		@(posedge clk);
		{rst_n, rr} <= 2'b01;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		`CHK("run restored", 1'b1, rro)
		@(posedge clk);
		{rst_n, rr, bv, bsel} <= 4'b0001;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		`CHK("backup error run", 1'b1, rro)
		`CHK("running", 1'b1, run_active)
		chk(OFF_STATUS, 32'h10, 32'h10, "status run");
		$display("done restore");

		apb(1'b0, 8'h1C, 32'h0, r, e);
		`CHK("unmapped err", 1'b1, e)
		`CHK("unmapped data", 32'h0, r)
		apb(1'b1, 8'h02, 32'hFFFFFFFF, r, e);
		`CHK("unaligned err", 1'b1, e)
		$display("done map");

		for (int i = 0; i < 5; i++) begin
			i_csf_prog_model.op(kind[i], bits[i]);
			chk(OFF_STATUS, 32'h1, {31'h0, bits[i]}, "carry flag");
		end
		$display("done carry");

		i_csf_prog_model.fault();
		repeat (3) @(posedge clk);
		`CHK("irq masked", 1'b0, irq)
		chk(OFF_STATUS, 32'h2, 32'h2, "fault flag");
		wr(OFF_INT_MASK, 32'h1);
		repeat (2) @(posedge clk);
		`CHK("irq on", 1'b1, irq)
		chk(OFF_INT_STATUS, 32'h1, 32'h1, "int fault");
		repeat (2) @(posedge clk);
		`CHK("irq cleared", 1'b0, irq)
		$display("done fault");

		for (int n = 1; n < 3; n++) begin
			i_csf_prog_model.node(n, 1'b1);
			chk(OFF_STATUS, 32'hC, 32'h4 << (n - 1), "node flag");
			i_csf_prog_model.node(n, 1'b0);
		end
		chk(OFF_INT_STATUS, 32'h6, 32'h6, "int nodes");
		$display("done nodes");

		// only defined control bits are ever written
		wr(OFF_CTRL, 32'h3);
		repeat (2) @(posedge clk);
		for (int i = 0; i < 20; i++) begin
			@(posedge clk);
			`CHK("tick held", 1'b0, tick)
		end
		wr(OFF_CTRL, 32'h1);
		seen = 1'b0;
		repeat (20) begin
			@(posedge clk);
			seen |= tick;
		end
		`CHK("tick free", 1'b1, seen)
		$display("done tick");

		wr(OFF_OUT_IMAGE, 32'hA5);
		repeat (3) @(posedge clk);
		`CHK("outs image", 8'hA5, outs)
		wr(OFF_OUT_LATCH_SET, 32'h0F);
		repeat (3) @(posedge clk);
		`CHK("outs latched", 8'hAF, outs)
		wr(OFF_CTRL, 32'h5);
		repeat (3) @(posedge clk);
		`CHK("outs forced off", 8'h00, outs)
		chk(OFF_OUT_STATE, 32'hFF, 32'h0, "out state off");
		wr(OFF_CTRL, 32'h1);
		repeat (3) @(posedge clk);
		`CHK("latch stays off", 8'hA5, outs)
		$display("done outputs");

		i_csf_prog_model.node(1, 1'b1);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			{stop, halt} <= (k == 0) ? 2'b10 : 2'b01;
			repeat (4) @(posedge clk);
			`CHK("stopped", 1'b0, run_active)
			wr(OFF_CTRL, 32'h7);
			chk(OFF_CTRL, 32'h7, 32'h1, "ctrl stopped");
			chk(OFF_STATUS, 32'h17, 32'h4, "status stopped");
			`CHK("outs stopped", 8'h00, outs)
			@(posedge clk);
			{stop, halt} <= 2'b00;
			repeat (4) @(posedge clk);
			`CHK("restarted", 1'b1, run_active)
		end
		chk(OFF_INT_STATUS, 32'h8, 32'h8, "int stop");
		wr(OFF_CTRL, 32'h0);
		repeat (4) @(posedge clk);
		`CHK("run cleared", 1'b0, run_active)
		`CHK("run flag out", 1'b0, rro)
		$display("done stop");
		final_report();
	end
endmodule // csf_flag_bank_tb
